// ### rep_consts.svh
// Constants for the retired-event counter and precise sampler.
// Assumes inclusion by bare name from the design files only.
`ifndef REP_CONSTS_SVH
`define REP_CONSTS_SVH

// -----------------------------------------------------------------
// Widths and sizes
// -----------------------------------------------------------------
`define REP_IP_W       48
`define REP_CTR_W      48
`define REP_CNT_W      3
`define REP_BHB_DEPTH  16
`define REP_BHB_IDX_W  4
`define REP_FILT_W     9
`define REP_BTYPE_W    7

// -----------------------------------------------------------------
// Event codes and sub-event masks
// -----------------------------------------------------------------
`define REP_EVT_INST    8'hc0
`define REP_EVT_UOPS    8'hc2
`define REP_EVT_BRANCH  8'hc4
`define REP_EVT_VECTOR  8'hc7
`define REP_EVT_ASSIST  8'hf7
`define REP_MASK_01     8'h01
`define REP_MASK_02     8'h02
`define REP_MASK_04     8'h04
`define REP_MASK_08     8'h08
`define REP_MASK_10     8'h10

// -----------------------------------------------------------------
// Filter bit positions and reset values
// -----------------------------------------------------------------
`define REP_FILT_RING0  0
`define REP_FILT_RING3  1
`define REP_FILT_TYPE0  2
`define REP_CTR_RST     48'h0000_0000_0000
`define REP_IP_RST      48'h0000_0000_0000
`define REP_PTR_RST     4'h0

`endif

// ### rep_pkg.sv
// Types shared by the retired-event sampler files.
// Assumes the constants header is compiled alongside.
package rep_pkg;

  // Precise sampling sequencer states
  typedef enum logic [1:0] {
    REP_IDLE  = 2'b00,
    REP_ARMED = 2'b01,
    REP_HELD  = 2'b10
  } rep_state_t;

endpackage

// ### rep_bhb.sv
// Rotating taken-branch history buffer of source and target pairs.
// Assumes branch info arrives at retirement, one branch per cycle.
`timescale 1ns/100ps
`include "rep_consts.svh"

module rep_bhb (
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  input  wire logic                        brTaken,
  input  wire logic                        brRing0,
  input  wire logic [`REP_BTYPE_W-1:0]     brType,
  input  wire logic [`REP_IP_W-1:0]        brSrc,
  input  wire logic [`REP_IP_W-1:0]        brTgt,
  input  wire logic [`REP_FILT_W-1:0]      filterBits,
  input  wire logic                        freeze,
  input  wire logic [`REP_BHB_IDX_W-1:0]   rdIdx,
  output logic      [`REP_IP_W-1:0]        rdSrc,
  output logic      [`REP_IP_W-1:0]        rdTgt,
  output logic      [`REP_BHB_IDX_W-1:0]   topIdx
);

  // -----------------------------------------------------------------
  // Record qualification
  // -----------------------------------------------------------------
  logic                      recordEn;
  logic                      ringOk;
  logic                      typeOk;
  logic [`REP_BHB_IDX_W-1:0] ptr_reg;
  logic [`REP_BHB_IDX_W-1:0] ptr_next;
  logic [`REP_IP_W-1:0]      srcMem [`REP_BHB_DEPTH];
  logic [`REP_IP_W-1:0]      tgtMem [`REP_BHB_DEPTH];
  logic [`REP_IP_W-1:0]      rdSrc_next;
  logic [`REP_IP_W-1:0]      rdTgt_next;

  // All-zero filter excludes nothing, so every taken branch lands while freeze is low
  always_comb begin
    ringOk   = brRing0 ? !filterBits[`REP_FILT_RING0]
                       : !filterBits[`REP_FILT_RING3];
    typeOk   = (brType & filterBits[`REP_FILT_W-1:`REP_FILT_TYPE0])
               == '0;
    recordEn = brTaken && ringOk && typeOk && !freeze;
    ptr_next = recordEn ? ptr_reg + 4'h1 : ptr_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ptr_reg <= `REP_PTR_RST;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // -----------------------------------------------------------------
  // Ring storage, oldest slot overwritten at the write pointer
  // -----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `REP_BHB_DEPTH; gi++) begin : gEntry
      logic [`REP_IP_W-1:0] srcNext;
      logic [`REP_IP_W-1:0] tgtNext;
      always_comb begin
        srcNext = srcMem[gi];
        tgtNext = tgtMem[gi];
        if (recordEn && ptr_reg == gi[`REP_BHB_IDX_W-1:0]) begin
          srcNext = brSrc;
          tgtNext = brTgt;
        end
      end
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          srcMem[gi] <= `REP_IP_RST;
          tgtMem[gi] <= `REP_IP_RST;
        end else begin
          srcMem[gi] <= srcNext;
          tgtMem[gi] <= tgtNext;
        end
      end
    end
  endgenerate

  // Registered read keeps data outputs off the storage mux
  always_comb begin
    rdSrc_next = srcMem[rdIdx];
    rdTgt_next = tgtMem[rdIdx];
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdSrc <= `REP_IP_RST;
      rdTgt <= `REP_IP_RST;
    end else begin
      rdSrc <= rdSrc_next;
      rdTgt <= rdTgt_next;
    end
  end

  // Most recent entry sits one behind the write pointer
  assign topIdx = ptr_reg - 4'h1;

endmodule // rep_bhb

// ### rep_sampler.sv
// Retired-event counter with precise sampling and deferred interrupt.
// Assumes retirement info is synchronous and valid every cycle.
`timescale 1ns/100ps
`include "rep_consts.svh"

module rep_sampler (
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  // Configuration
  input  wire logic                        ctrEnable,
  input  wire logic [7:0]                  evtSel,
  input  wire logic [7:0]                  subMask,
  input  wire logic [7:0]                  countThreshold,
  input  wire logic                        thresholdInvert,
  input  wire logic                        edgeDetect,
  input  wire logic                        countRing0,
  input  wire logic                        countRing3,
  input  wire logic                        preciseEnable,
  input  wire logic                        ctrWrite,
  input  wire logic [`REP_CTR_W-1:0]       ctrWrData,
  input  wire logic [`REP_FILT_W-1:0]      filterBits,
  // Retirement stream
  input  wire logic                        curRing0,
  input  wire logic                        intMasked,
  input  wire logic [`REP_IP_W-1:0]        retIp,
  input  wire logic [`REP_IP_W-1:0]        retNextIp,
  input  wire logic [`REP_CNT_W-1:0]       instRetired,
  input  wire logic [`REP_CNT_W-1:0]       uopsRetired,
  input  wire logic [`REP_CNT_W-1:0]       slotsUsed,
  input  wire logic [`REP_CNT_W-1:0]       fusedRetired,
  input  wire logic [`REP_CNT_W-1:0]       legacyFpRetired,
  input  wire logic [`REP_CNT_W-1:0]       multimediaRetired,
  input  wire logic [`REP_CNT_W-1:0]       vecPackedSingle,
  input  wire logic [`REP_CNT_W-1:0]       vecScalarSingle,
  input  wire logic [`REP_CNT_W-1:0]       vecPackedDouble,
  input  wire logic [`REP_CNT_W-1:0]       vecScalarDouble,
  input  wire logic [`REP_CNT_W-1:0]       vecInteger,
  input  wire logic                        assistValid,
  input  wire logic                        assistVector,
  input  wire logic                        assistInput,
  input  wire logic                        assistOutput,
  input  wire logic                        brRetired,
  input  wire logic                        brTaken,
  input  wire logic [`REP_BTYPE_W-1:0]     brType,
  // History buffer read
  input  wire logic [`REP_BHB_IDX_W-1:0]   bhbRdIdx,
  output logic      [`REP_IP_W-1:0]        bhbRdSrc,
  output logic      [`REP_IP_W-1:0]        bhbRdTgt,
  output logic      [`REP_BHB_IDX_W-1:0]   bhbTopIdx,
  // Results
  output logic      [`REP_CTR_W-1:0]       ctrValue,
  output logic      [`REP_IP_W-1:0]        sampleIp,
  output logic                             sampleValid,
  output logic                             samplePending,
  output logic                             counter_overflow_interrupt
);

  // -----------------------------------------------------------------
  // Event selection
  // -----------------------------------------------------------------
  logic [`REP_CNT_W-1:0] evtCnt;
  logic                  x87Assist;
  logic                  isBranchEvt;
  logic                  preciseOk;

  // Vector-instruction assists are dropped before any assist mask
  always_comb begin
    x87Assist   = assistValid && !assistVector;
    isBranchEvt = (evtSel == `REP_EVT_BRANCH);
    evtCnt      = '0;
    case (evtSel)
      `REP_EVT_INST: begin
        case (subMask)
          `REP_MASK_01: evtCnt = instRetired;
          `REP_MASK_02: evtCnt = legacyFpRetired;
          `REP_MASK_04: evtCnt = multimediaRetired;
          default:      evtCnt = '0;
        endcase
      end
      `REP_EVT_UOPS: begin
        case (subMask)
          `REP_MASK_01: evtCnt = uopsRetired;
          `REP_MASK_02: evtCnt = slotsUsed;
          `REP_MASK_04: evtCnt = fusedRetired;
          default:      evtCnt = '0;
        endcase
      end
      `REP_EVT_VECTOR: begin
        case (subMask)
          `REP_MASK_01: evtCnt = vecPackedSingle;
          `REP_MASK_02: evtCnt = vecScalarSingle;
          `REP_MASK_04: evtCnt = vecPackedDouble;
          `REP_MASK_08: evtCnt = vecScalarDouble;
          `REP_MASK_10: evtCnt = vecInteger;
          default:      evtCnt = '0;
        endcase
      end
      `REP_EVT_ASSIST: begin
        case (subMask)
          `REP_MASK_01: evtCnt = {2'b00, x87Assist};
          `REP_MASK_02: evtCnt = {2'b00, x87Assist && assistInput};
          `REP_MASK_04: evtCnt = {2'b00, x87Assist && assistOutput};
          default:      evtCnt = '0;
        endcase
      end
      `REP_EVT_BRANCH: begin
        evtCnt = (subMask == `REP_MASK_04) ? {2'b00, brRetired} : '0;
      end
      default: evtCnt = '0;
    endcase
    // Precise capture is offered for instruction and uop events under mask 01 and branch events under mask 04
    preciseOk = ((evtSel == `REP_EVT_INST || evtSel == `REP_EVT_UOPS)
                 && subMask == `REP_MASK_01)
                || (isBranchEvt && subMask == `REP_MASK_04);
  end

  // -----------------------------------------------------------------
  // Threshold, invert and edge qualification
  // -----------------------------------------------------------------
  logic                  cmpTrue;
  logic                  cmpPrev_reg;
  logic                  cmpPrev_next;
  logic                  ringOk;
  logic [`REP_CNT_W-1:0] incr;

  // Cycle events like halted cycles produce zero, which still passes
  // an inverted compare, so cycle counting needs no halt input
  always_comb begin
    ringOk = curRing0 ? countRing0 : countRing3;
    if (thresholdInvert) begin
      cmpTrue = {5'b00000, evtCnt} < countThreshold;
    end else begin
      cmpTrue = {5'b00000, evtCnt} >= countThreshold;
    end
    cmpPrev_next = cmpTrue;
    incr = '0;
    if (ctrEnable && ringOk) begin
      if (edgeDetect) begin
        incr = {2'b00, cmpTrue && !cmpPrev_reg};
      end else if (countThreshold == 8'h00 && !thresholdInvert) begin
        incr = evtCnt;
      end else begin
        incr = {2'b00, cmpTrue};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmpPrev_reg <= 1'b0;
    end else begin
      cmpPrev_reg <= cmpPrev_next;
    end
  end

  // -----------------------------------------------------------------
  // Counter and precise sample sequencer
  // -----------------------------------------------------------------
  rep_pkg::rep_state_t    state_reg;
  rep_pkg::rep_state_t    state_next;
  logic [`REP_CTR_W:0]    sum;
  logic                   overflow;
  logic [`REP_CTR_W-1:0]  ctr_reg;
  logic [`REP_CTR_W-1:0]  ctr_next;
  logic [`REP_IP_W-1:0]   ip_reg;
  logic [`REP_IP_W-1:0]   ip_next;
  logic                   valid_reg;
  logic                   valid_next;
  logic                   irq_reg;
  logic                   irq_next;

  // A sample is taken at the first counted instruction after wrap
  always_comb begin
    sum        = {1'b0, ctr_reg} + {{`REP_CTR_W-2{1'b0}}, incr};
    overflow   = sum[`REP_CTR_W];
    ctr_next   = ctrWrite ? ctrWrData : sum[`REP_CTR_W-1:0];
    state_next = state_reg;
    ip_next    = ip_reg;
    valid_next = valid_reg;
    irq_next   = 1'b0;
    case (state_reg)
      rep_pkg::REP_IDLE: begin
        if (overflow && !ctrWrite) begin
          if (preciseEnable && preciseOk) begin
            state_next = rep_pkg::REP_ARMED;
            valid_next = 1'b0;
          end else begin
            state_next = rep_pkg::REP_HELD;
          end
        end
      end
      rep_pkg::REP_ARMED: begin
        // Masking does not stop the capture, only the interrupt
        if (incr != '0) begin
          ip_next    = isBranchEvt ? retNextIp : retIp;
          valid_next = 1'b1;
          state_next = rep_pkg::REP_HELD;
        end
      end
      rep_pkg::REP_HELD: begin
        if (!intMasked) begin
          irq_next   = 1'b1;
          state_next = rep_pkg::REP_IDLE;
        end
      end
      default: state_next = rep_pkg::REP_IDLE;
    endcase
  end

  // Sample register only loads in ARMED, so it is frozen while held
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= rep_pkg::REP_IDLE;
      ctr_reg   <= `REP_CTR_RST;
      ip_reg    <= `REP_IP_RST;
      valid_reg <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctr_reg   <= ctr_next;
      ip_reg    <= ip_next;
      valid_reg <= valid_next;
      irq_reg   <= irq_next;
    end
  end

  assign ctrValue                   = ctr_reg;
  assign sampleIp                   = ip_reg;
  assign sampleValid                = valid_reg;
  assign samplePending              = (state_reg != rep_pkg::REP_IDLE);
  assign counter_overflow_interrupt = irq_reg;

  // -----------------------------------------------------------------
  // Branch history buffer, frozen while the sequencer is in HELD
  // -----------------------------------------------------------------
  // Freezing keeps the trail consistent with the sample; the cost is
  // that branches in the shadow before the interrupt are lost
  rep_bhb rep_bhb_i (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .brTaken    (brRetired && brTaken),
    .brRing0    (curRing0),
    .brType     (brType),
    .brSrc      (retIp),
    .brTgt      (retNextIp),
    .filterBits (filterBits),
    .freeze     (state_reg == rep_pkg::REP_HELD),
    .rdIdx      (bhbRdIdx),
    .rdSrc      (bhbRdSrc),
    .rdTgt      (bhbRdTgt),
    .topIdx     (bhbTopIdx)
  );

endmodule // rep_sampler

// ### rep_sampler_props.sv
// Concurrent checks on the retired-event sampler's ports.
// Assumes it is bound to rep_sampler and sees only that module's ports.
`timescale 1ns/100ps

module rep_sampler_props (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        ctrEnable,
  input wire logic [7:0]  evtSel,
  input wire logic [7:0]  subMask,
  input wire logic [7:0]  countThreshold,
  input wire logic        thresholdInvert,
  input wire logic        edgeDetect,
  input wire logic        countRing0,
  input wire logic        countRing3,
  input wire logic        preciseEnable,
  input wire logic        ctrWrite,
  input wire logic [8:0]  filterBits,
  input wire logic        intMasked,
  input wire logic [47:0] retIp,
  input wire logic [2:0]  instRetired,
  input wire logic [2:0]  uopsRetired,
  input wire logic        assistValid,
  input wire logic        assistVector,
  input wire logic        brRetired,
  input wire logic        brTaken,
  input wire logic [3:0]  bhbTopIdx,
  input wire logic [47:0] ctrValue,
  input wire logic [47:0] sampleIp,
  input wire logic        sampleValid,
  input wire logic        samplePending,
  input wire logic        counter_overflow_interrupt
);
  // ---------------------------------------------------------------
  // Helpers and assertions
  // ---------------------------------------------------------------
  // Level counting on every ring, no counter load in the way
  wire logic plainCfg = ctrEnable && countRing0 && countRing3
                        && !edgeDetect && !ctrWrite;
  wire logic thr0 = countThreshold == 8'h00 && !thresholdInvert;
  wire logic c0m1 = plainCfg && evtSel == 8'hc0 && subMask == 8'h01;
  wire logic c2m1 = plainCfg && evtSel == 8'hc2 && subMask == 8'h01;
  wire logic f7m1 = plainCfg && evtSel == 8'hf7 && subMask == 8'h01;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_inst_sum:
  assert property (c0m1 && thr0
    |=> ctrValue == $past(ctrValue) + $past(instRetired))
    else $error("instruction count not the exact sum");
  a_total_cycles:
  assert property (c0m1 && countThreshold == 8'h10 && thresholdInvert
    |=> ctrValue == $past(ctrValue) + 48'h1)
    else $error("total cycle count missed a cycle");
  a_uop_sum:
  assert property (c2m1 && thr0
    |=> ctrValue == $past(ctrValue) + $past(uopsRetired))
    else $error("uop count not the exact sum");
  a_stall_cycles:
  assert property (c2m1 && countThreshold == 8'h01 && thresholdInvert
    |=> ctrValue == $past(ctrValue) + ($past(uopsRetired) == 3'h0))
    else $error("stall cycle count wrong");
  a_assist_legacy:
  assert property (f7m1 && thr0 |=> ctrValue == $past(ctrValue)
    + $past(assistValid && !assistVector))
    else $error("assist count took a vector assist");
  a_capture_masked:
  assert property (c0m1 && thr0 && preciseEnable && $rose(samplePending)
    && instRetired != 3'h0 |=> sampleValid && sampleIp == $past(retIp))
    else $error("sample not captured after overflow");
  a_hold_frozen:
  assert property (samplePending && sampleValid && intMasked
    |=> samplePending && $stable(sampleIp) && !counter_overflow_interrupt)
    else $error("sample or interrupt moved while masked");
  a_irq_release:
  assert property (samplePending && sampleValid && !intMasked
    |=> counter_overflow_interrupt && !samplePending
    ##1 !counter_overflow_interrupt)
    else $error("interrupt not one pulse after unmask");
  a_irq_unmasked:
  assert property (counter_overflow_interrupt |-> !$past(intMasked))
    else $error("interrupt raised while masked");
  a_bhb_rotate:
  assert property (brRetired && brTaken && filterBits == 9'h000
    && !samplePending |=> bhbTopIdx == $past(bhbTopIdx) + 4'h1)
    else $error("history pointer did not advance");
  a_bhb_still:
  assert property (!(brRetired && brTaken) |=> $stable(bhbTopIdx))
    else $error("history moved without a taken branch");
endmodule // rep_sampler_props

bind rep_sampler rep_sampler_props rep_sampler_props_i (.sys_clk, .srst,
  .ctrEnable, .evtSel, .subMask, .countThreshold, .thresholdInvert,
  .edgeDetect, .countRing0, .countRing3, .preciseEnable, .ctrWrite,
  .filterBits, .intMasked, .retIp, .instRetired, .uopsRetired, .assistValid,
  .assistVector, .brRetired, .brTaken, .bhbTopIdx, .ctrValue, .sampleIp,
  .sampleValid, .samplePending, .counter_overflow_interrupt);

// ### tb_rep_sampler.sv
// Self-checking bench for the retired-event sampler.
// Assumes the design files and the bound checker are compiled first.
`timescale 1ns/100ps

module tb_rep_sampler;
  logic sys_clk = 0, srst = 1, ctrEnable = 0, thresholdInvert = 0;
  logic edgeDetect = 0, countRing0 = 1, countRing3 = 1, preciseEnable = 0;
  logic ctrWrite = 0, curRing0 = 0, intMasked = 0, assistValid = 0;
  logic assistVector = 0, assistInput = 0, assistOutput = 0;
  logic brRetired = 0, brTaken = 0;
  logic [7:0]  evtSel = 8'h00, subMask = 8'h00, countThreshold = 8'h00;
  logic [47:0] ctrWrData = 48'h0, retIp = 48'h0, retNextIp = 48'h0;
  logic [8:0]  filterBits = 9'h000;
  logic [6:0]  brType = 7'h01;
  logic [3:0]  bhbRdIdx = 4'h0;
  logic [2:0]  instRetired = 3'h0, uopsRetired = 3'h0, slotsUsed = 3'h0;
  logic [2:0]  fusedRetired = 3'h0, legacyFpRetired = 3'h0;
  logic [2:0]  multimediaRetired = 3'h0, vecPackedSingle = 3'h0;
  logic [2:0]  vecScalarSingle = 3'h0, vecPackedDouble = 3'h0;
  logic [2:0]  vecScalarDouble = 3'h0, vecInteger = 3'h0;
  wire logic [47:0] bhbRdSrc, bhbRdTgt, ctrValue, sampleIp;
  wire logic [3:0]  bhbTopIdx;
  wire logic        sampleValid, samplePending, counter_overflow_interrupt;
  int bad_count = 0, tests_run = 0, cycles = 0;
  // Rows: event, mask, threshold, {ring0 only, edge, vector assist, invert},
  // count per cycle
  logic [31:0] evtTab [26] = '{
    32'hc001_0001, 32'hc002_0002, 32'hc004_0003, 32'hc201_0004,
    32'hc202_0005, 32'hc204_0006, 32'hc701_0002, 32'hc702_0003,
    32'hc704_0005, 32'hc708_0006, 32'hc710_0007, 32'hf701_0001,
    32'hf702_0001, 32'hf704_0000, 32'hf701_0020, 32'hc001_1011,
    32'hc001_ff11, 32'hc201_0101, 32'hc201_0110, 32'hc201_0401,
    32'hc201_0500, 32'hc201_0511, 32'hc008_0000, 32'hc404_0001,
    32'hc201_0140, 32'hc001_1090};

  rep_sampler rep_sampler_i (.sys_clk, .srst, .ctrEnable, .evtSel,
    .subMask, .countThreshold, .thresholdInvert, .edgeDetect, .countRing0,
    .countRing3, .preciseEnable, .ctrWrite, .ctrWrData, .filterBits,
    .curRing0, .intMasked, .retIp, .retNextIp, .instRetired, .uopsRetired,
    .slotsUsed, .fusedRetired, .legacyFpRetired, .multimediaRetired,
    .vecPackedSingle, .vecScalarSingle, .vecPackedDouble, .vecScalarDouble,
    .vecInteger, .assistValid, .assistVector, .assistInput, .assistOutput,
    .brRetired, .brTaken, .brType, .bhbRdIdx, .bhbRdSrc, .bhbRdTgt,
    .bhbTopIdx, .ctrValue, .sampleIp, .sampleValid, .samplePending,
    .counter_overflow_interrupt);

  // ---------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------
  initial forever #50 sys_clk = ~sys_clk;

  // Whole run needs about 212 cycles; over fourteen times that means a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("wrong value at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  // Inputs always change 10 ns after the edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask

  task automatic chk(input logic [47:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h",
               $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // 17 taken branches wrap the 16-slot ring; slot 0 is overwritten
  task automatic t_history;
    for (int i = 0; i < 17; i++) begin
      brRetired = 1;
      brTaken = 1;
      brType = 7'h01 << (i % 7);
      curRing0 = i[0];
      retIp = 48'(i + 1);
      retNextIp = 48'(i + 'h100);
      step(1);
    end
    brTaken = 0;
    step(1);
    brRetired = 0;
    chk(48'(bhbTopIdx), 48'h0, "newest slot");
    bhbRdIdx = 4'h0;
    step(1);
    chk(bhbRdSrc, 48'h11, "slot 0 source");
    chk(bhbRdTgt, 48'h110, "slot 0 target");
    bhbRdIdx = 4'h1;
    step(1);
    chk(bhbRdSrc, 48'h2, "slot 1 source");
    chk(bhbRdTgt, 48'h101, "slot 1 target");
  endtask

  // Every code and mask, thresholds both sides of the count, 4 cycles each
  task automatic t_events;
    {instRetired, legacyFpRetired, multimediaRetired} = {3'h1, 3'h2, 3'h3};
    {uopsRetired, slotsUsed, fusedRetired} = {3'h4, 3'h5, 3'h6};
    {vecPackedSingle, vecScalarSingle, vecPackedDouble} = {3'h2, 3'h3, 3'h5};
    {vecScalarDouble, vecInteger} = {3'h6, 3'h7};
    {assistValid, assistInput, brRetired} = 3'b111;
    for (int i = 0; i < 26; i++) begin
      {evtSel, subMask, countThreshold} = evtTab[i][31:8];
      {countRing3, edgeDetect} = {!evtTab[i][7], evtTab[i][6]};
      {assistVector, thresholdInvert} = evtTab[i][5:4];
      ctrWrData = 48'h0;
      ctrWrite = 1;
      step(1);
      ctrWrite = 0;
      ctrEnable = 1;
      step(4);
      ctrEnable = 0;
      step(1);
      chk(ctrValue, 48'(evtTab[i][3:0]) * 48'h4,
          "event count");
    end
    {assistValid, assistInput, assistVector, brRetired} = 4'b0000;
    {countRing3, edgeDetect} = 2'b10;
  endtask

  // Overflow while masked: capture, stay frozen, interrupt after unmask
  task automatic t_precise(input logic [7:0] evt, msk,
                           input logic [47:0] expIp);
    int waitN;
    {evtSel, subMask, countThreshold, thresholdInvert} = {evt, msk, 9'h000};
    {instRetired, uopsRetired} = {3'h1, 3'h1};
    {preciseEnable, brRetired, brTaken, intMasked} = 4'b1101;
    ctrWrData = 48'hffff_ffff_ffff;
    ctrWrite = 1;
    ctrEnable = 1;
    step(1);
    ctrWrite = 0;
    step(1);
    chk(48'(samplePending), 48'h1, "armed after overflow");
    retIp = 48'h0000_1234_5678;
    retNextIp = 48'h0000_9abc_def0;
    step(1);
    retIp = 48'h0;
    retNextIp = 48'h0;
    step(3);
    chk(48'(sampleValid), 48'h1, "sample taken while masked");
    chk(sampleIp, expIp, "sampled address");
    chk(48'(counter_overflow_interrupt), 48'h0, "early interrupt");
    intMasked = 0;
    waitN = 0;
    while (counter_overflow_interrupt !== 1'b1 && waitN < 4) begin
      step(1);
      waitN++;
    end
    chk(48'(waitN), 48'h1, "interrupt delay after unmask");
    step(1);
    chk(48'(counter_overflow_interrupt), 48'h0, "interrupt pulse");
    chk(48'(samplePending), 48'h0, "sequence idle again");
    {ctrEnable, preciseEnable, brRetired, instRetired} = 6'h00;
  endtask

  // Reset for 12 cycles, then every scenario in turn
  initial begin
    step(12);
    srst = 0;
    chk(ctrValue, 48'h0, "counter after reset");
    chk(48'(bhbTopIdx), 48'hf, "newest slot after reset");
    t_history();
    t_events();
    t_precise(8'hc0, 8'h01, 48'h0000_1234_5678);
    t_precise(8'hc2, 8'h01, 48'h0000_1234_5678);
    t_precise(8'hc4, 8'h04, 48'h0000_9abc_def0);
    tally_and_finish();
  end
endmodule // tb_rep_sampler
